// *** src/cpa_adder.sv ***
// Adder with carry-out and overflow for word or byte width.
`timescale 1ns/100ps
`default_nettype none
module cpa_adder
	import cpa_pkg::*;
#(
	parameter int W = CPA_W
) (
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic cin,
	input wire logic byte_op,
	output logic [W-1:0] sum,
	output logic cout,
	output logic ovf
);
	logic [W:0] full;
	logic [8:0] low;
	always_comb begin
		full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
		low = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
		sum = full[W-1:0];
		if (byte_op) begin
			cout = low[8];
			ovf = (a[7] == b[7]) && (low[7] != a[7]);
		end else begin
			cout = full[W];
			ovf = (a[W-1] == b[W-1]) && (full[W-1] != a[W-1]);
		end
	end
endmodule : cpa_adder
`default_nettype wire

// *** src/cpa_alu.sv ***
// Datapath for carry, sign fill, status moves, move, compare, add, subtract.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Add-carry adds the carry flag to the destination and writes it.
// - Subtract-carry subtracts the carry flag from the destination.
// - Subtract-carry sets V on 100000 and C on zero with carry.
// - Sign fill writes zero when N clear and all ones when set.
// - Status read copies the low byte; register gets bit 7 extended.
// - Status write loads the low status byte from the source, T and priority bits limited as below.
// - Status write never sets the trace bit.
// - Status write changes priority bits only in kernel mode.
// - Status write loads the flags from source bits 3 to 0.
// - Status write treats its source address as a byte address.
// - Moves copy source; N and Z from source, V cleared, C kept.
// - Byte move to register sign-extends; to memory writes one byte.
// - Compare computes source minus destination and writes nothing.
// - Compare V on opposite signs with destination sign equal result.
// - Compare C set when no carry leaves the top bit.
module cpa_alu
	import cpa_pkg::*;
#(
	parameter int W = CPA_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire cpa_req_s req,
	output logic done,
	output cpa_out_s out,
	output logic [15:0] status_word
);
	logic [15:0] psw_reg;
	logic [15:0] psw_next;
	cpa_out_s out_reg;
	cpa_out_s out_next;
	logic done_reg;
	logic done_next;
	logic [15:0] add_a;
	logic [15:0] add_b;
	logic add_cin;
	logic [15:0] add_sum;
	logic add_cout;
	logic add_ovf;
	logic [15:0] res;
	logic n_f;
	logic z_f;
	logic v_f;
	logic c_f;
	logic c_in;
	logic [7:0] sb;

	assign c_in = psw_reg[CPA_PSW_C];

	cpa_adder #(.W(W)) u_add (
		.a(add_a),
		.b(add_b),
		.cin(add_cin),
		.byte_op(req.byte_op),
		.sum(add_sum),
		.cout(add_cout),
		.ovf(add_ovf)
	);

	always_comb begin
		add_a = req.dst;
		add_b = 16'h0000;
		add_cin = 1'b0;
		case (req.op)
			CPA_OP_ADD_CARRY: begin
				add_cin = c_in;
			end
			CPA_OP_SUBTRACT_BORROW: begin
				add_b = 16'hFFFF;
				add_cin = ~c_in;
			end
			CPA_OP_COMPARE: begin
				add_a = req.src;
				add_b = ~req.dst;
				add_cin = 1'b1;
			end
			CPA_OP_ADD: begin
				add_b = req.src;
			end
			CPA_OP_SUB: begin
				add_b = ~req.src;
				add_cin = 1'b1;
			end
			default: begin
				add_b = 16'h0000;
			end
		endcase
	end

	always_comb begin
		psw_next = psw_reg;
		out_next = out_reg;
		done_next = 1'b0;
		res = add_sum;
		v_f = psw_reg[CPA_PSW_V];
		c_f = c_in;
		sb = req.src[7:0];
		n_f = 1'b0;
		z_f = 1'b0;
		if (req_valid) begin
			done_next = 1'b1;
			out_next.write_dst = 1'b1;
			out_next.byte_write = req.byte_op;
			out_next.byte_addr_src = 1'b0;
			case (req.op)
				CPA_OP_ADD_CARRY: begin
					res = add_sum;
					if (req.byte_op) begin
						v_f = (req.dst[7:0] == 8'h7F) && c_in;
						c_f = (req.dst[7:0] == 8'hFF) && c_in;
					end else begin
						v_f = (req.dst == 16'h7FFF) && c_in;
						c_f = (req.dst == 16'hFFFF) && c_in;
					end
				end
				CPA_OP_SUBTRACT_BORROW: begin
					res = add_sum;
					if (req.byte_op) begin
						v_f = req.dst[7:0] == 8'h80;
						c_f = (req.dst[7:0] == 8'h00) && c_in;
					end else begin
						v_f = req.dst == 16'h8000;
						c_f = (req.dst == 16'h0000) && c_in;
					end
				end
				CPA_OP_SIGN_FILL: begin
					res = psw_reg[CPA_PSW_N] ? 16'hFFFF : 16'h0000;
					v_f = 1'b0;
					out_next.byte_write = 1'b0;
				end
				CPA_OP_STATUS_READ: begin
					res = {{8{psw_reg[7]}}, psw_reg[7:0]};
					v_f = 1'b0;
					out_next.byte_write = ~req.dst_is_reg;
				end
				CPA_OP_STATUS_WRITE: begin
					res = req.dst;
					out_next.write_dst = 1'b0;
					out_next.byte_addr_src = 1'b1;
				end
				CPA_OP_COPY: begin
					if (req.byte_op && req.dst_is_reg) begin
						res = {{8{req.src[7]}}, req.src[7:0]};
						out_next.byte_write = 1'b0;
					end else begin
						res = req.src;
					end
					v_f = 1'b0;
				end
				CPA_OP_COMPARE: begin
					res = add_sum;
					out_next.write_dst = 1'b0;
					if (req.byte_op) begin
						v_f = (req.src[7] != req.dst[7]) &&
							(req.dst[7] == add_sum[7]);
					end else begin
						v_f = (req.src[15] != req.dst[15]) &&
							(req.dst[15] == add_sum[15]);
					end
					c_f = ~add_cout;
				end
				CPA_OP_ADD: begin
					res = add_sum;
					v_f = add_ovf;
					c_f = add_cout;
				end
				CPA_OP_SUB: begin
					res = add_sum;
					v_f = add_ovf;
					c_f = ~add_cout;
				end
				default: begin
					out_next.write_dst = 1'b0;
				end
			endcase
			out_next.result = res;
			if (req.op == CPA_OP_STATUS_WRITE) begin
				psw_next[3:0] = sb[3:0];
				psw_next[CPA_PSW_T] = psw_reg[CPA_PSW_T] & sb[4];
				if (req.mode == CPA_MODE_KERNEL) begin
					psw_next[CPA_PSW_PRI_HI:CPA_PSW_PRI_LO] =
						sb[7:5];
				end
			end else if (req.op != CPA_OP_NONE &&
				req.op <= CPA_OP_SUB) begin
				if (req.op == CPA_OP_COPY) begin
					n_f = req.byte_op ? req.src[7] : req.src[15];
					z_f = req.byte_op ? (req.src[7:0] == 8'h00) :
						(req.src == 16'h0000);
				end else if (req.byte_op && req.op != CPA_OP_SIGN_FILL &&
					req.op != CPA_OP_STATUS_READ) begin
					n_f = res[7];
					z_f = res[7:0] == 8'h00;
				end else if (req.op == CPA_OP_STATUS_READ) begin
					n_f = res[7];
					z_f = res[7:0] == 8'h00;
				end else begin
					n_f = res[15];
					z_f = res == 16'h0000;
				end
				if (req.op == CPA_OP_SIGN_FILL) begin
					n_f = psw_reg[CPA_PSW_N];
				end
				psw_next[CPA_PSW_N] = n_f;
				psw_next[CPA_PSW_Z] = z_f;
				psw_next[CPA_PSW_V] = v_f;
				if (req.op != CPA_OP_STATUS_READ && req.op != CPA_OP_SIGN_FILL) begin
					psw_next[CPA_PSW_C] = c_f;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			psw_reg <= CPA_PSW_RST;
			out_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			psw_reg <= psw_next;
			out_reg <= out_next;
			done_reg <= done_next;
		end
	end

	assign done = done_reg;
	assign out = out_reg;
	assign status_word = psw_reg;
endmodule : cpa_alu
`default_nettype wire

// *** src/cpa_pkg.sv ***
// Package with operation codes, status layout and carriers for the ALU.
package cpa_pkg;
	localparam int CPA_W = 16;
	localparam int CPA_PSW_C = 0;
	localparam int CPA_PSW_V = 1;
	localparam int CPA_PSW_Z = 2;
	localparam int CPA_PSW_N = 3;
	localparam int CPA_PSW_T = 4;
	localparam int CPA_PSW_PRI_LO = 5;
	localparam int CPA_PSW_PRI_HI = 7;
	localparam logic [15:0] CPA_PSW_RST = 16'h0000;
	localparam logic [15:0] CPA_RES_RST = 16'h0000;
	localparam logic [1:0] CPA_MODE_KERNEL = 2'h0;

	typedef enum logic [3:0] {
		CPA_OP_NONE = 4'h0,
		CPA_OP_ADD_CARRY = 4'h1,
		CPA_OP_SUBTRACT_BORROW = 4'h2,
		CPA_OP_SIGN_FILL = 4'h3,
		CPA_OP_STATUS_READ = 4'h4,
		CPA_OP_STATUS_WRITE = 4'h5,
		CPA_OP_COPY = 4'h6,
		CPA_OP_COMPARE = 4'h7,
		CPA_OP_ADD = 4'h8,
		CPA_OP_SUB = 4'h9
	} cpa_op_e;

	typedef struct packed {
		cpa_op_e op;
		logic byte_op;
		logic dst_is_reg;
		logic [15:0] src;
		logic [15:0] dst;
		logic [1:0] mode;
	} cpa_req_s;

	typedef struct packed {
		logic [15:0] result;
		logic write_dst;
		logic byte_write;
		logic byte_addr_src;
	} cpa_out_s;
endpackage : cpa_pkg

// *** test/cpa_alu_assertions.sv ***
// Concurrent checks on the ALU datapath ports.
`timescale 1ns/100ps
`default_nettype none
module cpa_alu_chk
	import cpa_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire cpa_req_s req,
	input wire logic done,
	input wire cpa_out_s out,
	input wire logic [15:0] status_word
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire cpa_op_e o = req.op;
	wire logic v = req_valid;
	wire logic w = req_valid && !req.byte_op;
	wire logic [15:0] s = req.src;
	wire logic [15:0] d = req.dst;
	wire logic [15:0] r = out.result;
	wire logic [15:0] p = status_word;
	a_add_sum: assert property (
		w && o == CPA_OP_ADD |=> r == $past(s) + $past(d)) else $error("add");
	a_sub_diff: assert property (
		w && o == CPA_OP_SUB |=> r == $past(d) - $past(s)) else $error("sub");
	a_carry_add: assert property (
		w && o == CPA_OP_ADD_CARRY |=> r == $past(d) + $past(p[0]))
		else $error("add carry");
	a_carry_sub: assert property (
		w && o == CPA_OP_SUBTRACT_BORROW |=> r == $past(d) - $past(p[0]))
		else $error("sub carry");
	a_fill_sign: assert property (
		w && o == CPA_OP_SIGN_FILL |=> r == {16{$past(p[3])}})
		else $error("sign fill");
	a_cmp_hold: assert property (
		v && o == CPA_OP_COMPARE |=> !out.write_dst) else $error("compare");
	a_trace_clr: assert property (
		v && o == CPA_OP_STATUS_WRITE && !p[4] |=> !p[4]) else $error("trace");
	a_pri_keep: assert property (
		v && o == CPA_OP_STATUS_WRITE && req.mode != CPA_MODE_KERNEL
		|=> p[7:5] == $past(p[7:5])) else $error("priority");
	a_cc_load: assert property (
		v && o == CPA_OP_STATUS_WRITE |=> p[3:0] == $past(s[3:0]))
		else $error("flags");
	c_cmp: cover property (v && o == CPA_OP_COMPARE);
	c_user: cover property (v && req.mode != CPA_MODE_KERNEL);
	c_sbc: cover property (v && o == CPA_OP_SUBTRACT_BORROW && p[0]);
endmodule : cpa_alu_chk
bind cpa_alu cpa_alu_chk u_chk (.clk(clk), .sys_rst(sys_rst),
	.req_valid(req_valid), .req(req), .done(done), .out(out),
	.status_word(status_word));
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking testbench for the ALU datapath.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
	$display("wrong value %s exp %h got %h", n, e, a); end end
module tb_top
	import cpa_pkg::*;
;
	localparam logic [15:0] F = 16'hFFFF;
	localparam logic [1:0] K = CPA_MODE_KERNEL;
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	logic req_valid = 1'h0;
	cpa_req_s req = '0;
	logic done;
	cpa_out_s out;
	logic [15:0] status_word;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	cpa_alu dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
		.req(req), .done(done), .out(out), .status_word(status_word));
	task automatic end_sim();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic run(cpa_op_e op, logic [1:0] t, logic [15:0] s, d,
		logic [1:0] m, logic [15:0] er, mk, logic [3:0] ef);
		req = '{op, t[1], t[0], s, d, m};
		req_valid = 1'h1;
		@(negedge clk);
		`CHK("done", 1'h1, done)
		`CHK("result", er, out.result & mk)
		`CHK("flags", ef, status_word[3:0])
	endtask : run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 500) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		repeat (6) @(negedge clk);
		`CHK("reset", 16'h0000, status_word)
		sys_rst = 1'h0;
		@(negedge clk);
		run(CPA_OP_ADD, 2'h1, F, 16'h0001, K, 16'h0000, F, 4'h5);
		run(CPA_OP_ADD_CARRY, 2'h1, 0, 16'h7FFF, K, 16'h8000, F, 4'hA);
		run(CPA_OP_STATUS_WRITE, 2'h1, 16'h0001, 0, K, 0, F, 4'h1);
		run(CPA_OP_SUBTRACT_BORROW, 2'h1, 0, 0, K, F, F, 4'h9);
		run(CPA_OP_SUBTRACT_BORROW, 2'h1, 0, 16'h8000, K, 16'h7FFF, F, 4'h2);
		$display("test carry done");
		run(CPA_OP_SIGN_FILL, 2'h1, 0, 16'h1234, K, 0, F, 4'h4);
		run(CPA_OP_STATUS_WRITE, 2'h1, 16'h00FF, 0, K, 0, F, 4'hF);
		`CHK("status", 16'h00EF, status_word)
		`CHK("byte source", 1'h1, out.byte_addr_src)
		`CHK("write", 1'h0, out.write_dst)
		run(CPA_OP_SIGN_FILL, 2'h1, 0, 0, K, F, F, 4'h9);
		run(CPA_OP_COPY, 2'h1, 0, 16'h1234, K, 0, F, 4'h5);
		run(CPA_OP_STATUS_WRITE, 2'h1, 0, 0, 2'h3, 0, F, 4'h0);
		`CHK("status", 16'h00E0, status_word)
		run(CPA_OP_STATUS_READ, 2'h1, 0, 0, K, 16'hFFE0, F, 4'h8);
		run(CPA_OP_STATUS_READ, 2'h0, 0, 0, K, 16'h00E8, 16'h00FF, 4'h8);
		$display("test status done");
		run(CPA_OP_COPY, 2'h3, 16'h0080, 1, K, 16'hFF80, F, 4'h8);
		run(CPA_OP_COPY, 2'h2, 16'h0080, 1, K, 16'h0080, 16'h00FF, 4'h8);
		`CHK("byte write", 1'h1, out.byte_write)
		$display("test move done");
		run(CPA_OP_COMPARE, 2'h1, 1, 2, K, 0, 0, 4'h9);
		`CHK("write", 1'h0, out.write_dst)
		run(CPA_OP_COMPARE, 2'h1, 16'h8000, 1, K, 0, 0, 4'h2);
		run(CPA_OP_SUB, 2'h1, 1, 3, K, 16'h0002, F, 4'h0);
		run(CPA_OP_SUB, 2'h1, 3, 1, K, 16'hFFFE, F, 4'h9);
		run(CPA_OP_NONE, 2'h1, 3, 1, K, 0, 0, 4'h9);
		`CHK("write", 1'h0, out.write_dst)
		run(cpa_op_e'(4'hA), 2'h1, 3, 1, K, 0, 0, 4'h9);
		`CHK("write", 1'h0, out.write_dst)
		req_valid = 1'h0;
		@(negedge clk);
		`CHK("done", 1'h0, done)
		$display("test compare done");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
